// ==== core/wwdm_top.sv ====
// Window watchdog monitor: heartbeat spacing check and reset pulse
//
// Overview of operation
// - Measure rising-edge spacing, fault outside window.
// - Any fault drives reset low for pulse time.
// - Short spacing is fast, long is slow.
// - Max from resistor setting; min is max/8.
// - Watchdog idle unless enable pin is low.
// - Arm after both rails good for activation delay.
// - No edge in delay plus max: pulse, clear.
// - Repeat missing-edge pulse until edges resume.
`timescale 1ns/1ps
module wwdm_top #(
    parameter int unsigned FAULT_CYC = wwdm_pkg::FAULT_PULSE_CYC,
    parameter int unsigned ACT_CYC   = wwdm_pkg::ACT_DELAY_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic                        heartbeat_input,
    input  wire logic                        window_check_enable_low,
    input  wire logic                        rail_primary_good,
    input  wire logic                        rail_secondary_good,
    input  wire logic [wwdm_pkg::CNT_W-1:0]  max_interval_cycles,
    output logic                             reset_out_low,
    output logic                             fast_fault,
    output logic                             slow_fault,
    output logic                             fault_internal_flag,
    output logic                             watchdog_active
);
    import wwdm_pkg::*;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // OFF: disarmed; START: waiting for the first edge after arming or
    // after a fault; RUN: window checking; FAULT: reset pulse running
    typedef enum logic [1:0] {
        ST_OFF,
        ST_START,
        ST_RUN,
        ST_FAULT
    } wwdm_state_t;

    // All state of the block except the reset release flops: sync stages, counters and output flops
    typedef struct packed {
        logic [1:0]       hb_sync;
        logic [1:0]       en_sync;
        logic [1:0]       rp_sync;
        logic [1:0]       rs_sync;
        logic             hb_prev;
        wwdm_state_t      state;
        // Rail good time, then interval, wait or pulse time
        logic [CNT_W-1:0] rail_cnt;
        logic [CNT_W-1:0] cnt;
        // Output flops; the reset output is held at its pin level
        logic             rst_out_n;
        logic             fast;
        logic             slow;
        logic             flag;
        logic             active;
    } wwdm_regs_t;

    // ------------------------------------------------------------------
    // Internal signals
    // ------------------------------------------------------------------
    logic [1:0]  rst_sync_r;
    logic        rst_n;
    wwdm_regs_t  st_r;
    wwdm_regs_t  st_nxt;
    logic        hb_rise;
    logic        rails_ok;
    logic        armed;
    logic [CNT_W-1:0] min_cyc;
    logic [CNT_W-1:0] start_lim;
    logic [CNT_W-1:0] elapsed;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    // Two flops release the asynchronous reset on a clock edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_r <= SYNC_RESET;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    // The rest of the design resets from the released copy
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------------
    // Window limits and qualifiers
    // ------------------------------------------------------------------
    // Rising edge taken from the second sync stage only
    assign hb_rise   = st_r.hb_sync[1] & ~st_r.hb_prev;
    // Both rails good and the enable pin low arm the watchdog
    assign rails_ok  = st_r.rp_sync[1] & st_r.rs_sync[1];
    assign armed     = ~st_r.en_sync[1] & rails_ok;
    // Minimum spacing is one eighth of the maximum; the division
    // truncates, so a maximum below eight cycles has no fast limit
    assign min_cyc   = max_interval_cycles / WINDOW_DIV;
    // The first edge may take the activation delay plus one window
    assign start_lim = CNT_W'(ACT_CYC) + max_interval_cycles;
    // Cycles since the last accepted edge or state change, this one in
    assign elapsed   = st_r.cnt + 1'b1;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // Two-flop synchronisers for the heartbeat, enable and rail pins
        st_nxt.hb_sync = {st_r.hb_sync[0], heartbeat_input};
        st_nxt.en_sync = {st_r.en_sync[0], window_check_enable_low};
        st_nxt.rp_sync = {st_r.rp_sync[0], rail_primary_good};
        st_nxt.rs_sync = {st_r.rs_sync[0], rail_secondary_good};
        st_nxt.hb_prev = st_r.hb_sync[1];
        // Fault strobes last one cycle
        st_nxt.fast    = 1'b0;
        st_nxt.slow    = 1'b0;
        // Rail good time, restarts on any dip
        if (!rails_ok) begin
            st_nxt.rail_cnt = '0;
        end else if (st_r.rail_cnt < CNT_W'(ACT_CYC)) begin
            st_nxt.rail_cnt = st_r.rail_cnt + 1'b1;
        end
        // Main sequence
        case (st_r.state)
            ST_OFF: begin
                // Interval counter held clear while disarmed; rail time keeps counting
                st_nxt.cnt = '0;
                st_nxt.rst_out_n = 1'b1;
                st_nxt.active = 1'b0;
                // Arm once the rails have been good for the whole delay
                if (armed && st_r.rail_cnt >= CNT_W'(ACT_CYC)) begin
                    st_nxt.state = ST_START;
                    st_nxt.active = 1'b1;
                end
            end
            ST_START: begin
                // Waiting for first edge after arming or after a fault
                // The first edge only restarts timing; it is not checked
                st_nxt.cnt = elapsed;
                if (hb_rise) begin
                    st_nxt.cnt = '0;
                    st_nxt.state = ST_RUN;
                end else if (elapsed >= start_lim) begin
                    st_nxt.slow = 1'b1;
                    st_nxt.cnt = '0;
                    st_nxt.rst_out_n = 1'b0;
                    st_nxt.flag = 1'b1;
                    st_nxt.state = ST_FAULT;
                end
            end
            ST_RUN: begin
                // An early edge is fast, a late or absent one slow
                st_nxt.cnt = elapsed;
                if (hb_rise && elapsed < min_cyc) begin
                    st_nxt.fast = 1'b1;
                end else if (hb_rise) begin
                    st_nxt.cnt = '0;
                end else if (elapsed >= max_interval_cycles) begin
                    st_nxt.slow = 1'b1;
                end
                // Either fault starts the reset pulse
                if (st_nxt.fast || st_nxt.slow) begin
                    st_nxt.cnt = '0;
                    st_nxt.rst_out_n = 1'b0;
                    st_nxt.flag = 1'b1;
                    st_nxt.state = ST_FAULT;
                end
            end
            ST_FAULT: begin
                // Hold reset low for the pulse, then re-arm the wait
                // Pulse length counts from the cycle the output went low
                st_nxt.cnt = elapsed;
                if (st_r.cnt >= CNT_W'(FAULT_CYC - 1)) begin
                    st_nxt.cnt = '0;
                    st_nxt.rst_out_n = 1'b1;
                    st_nxt.flag = 1'b0;
                    st_nxt.state = ST_START;
                end
            end
            // Unused state codes fall back to OFF
            default: begin
                st_nxt.state = ST_OFF;
            end
        endcase
        // Disable or rail loss stops the watchdog at once
        // An ongoing reset pulse is cut short and the output released
        if (!armed) begin
            st_nxt.state = ST_OFF;
            st_nxt.cnt = '0;
            st_nxt.rst_out_n = 1'b1;
            st_nxt.flag = 1'b0;
            st_nxt.active = 1'b0;
            st_nxt.fast = 1'b0;
            st_nxt.slow = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset leaves the reset output released (high)
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{state: ST_OFF, rst_out_n: RST_OUT_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------------
    assign reset_out_low       = st_r.rst_out_n;
    assign fast_fault          = st_r.fast;
    assign slow_fault          = st_r.slow;
    assign fault_internal_flag = st_r.flag;
    assign watchdog_active     = st_r.active;
endmodule

// ==== core/wwdm_pkg.sv ====
// Constants for the window watchdog monitor
package wwdm_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FAULT_PULSE_US  = 2000;   // Reset pulse, us
    localparam int unsigned ACT_DELAY_US    = 30000;  // Activation delay, us
    localparam int unsigned MAX_INTERVAL_US = 10000;  // Default window, us
    localparam int unsigned WINDOW_DIV      = 8;      // Min = max / 8
    localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
    localparam int unsigned FAULT_PULSE_CYC = FAULT_PULSE_US * CYC_PER_US;
    localparam int unsigned ACT_DELAY_CYC   = ACT_DELAY_US * CYC_PER_US;
    localparam int unsigned MAX_INTERVAL_CYC = MAX_INTERVAL_US * CYC_PER_US;
    localparam int unsigned CNT_W           = 32;
    localparam logic [1:0]  SYNC_RESET      = 2'h0;
    localparam logic        RST_OUT_IDLE    = 1'b1;   // Reset output released
endpackage

// ==== testbench/wwdm_monitor.sv ====
// Port checker for the window watchdog monitor
`timescale 1ns/1ps
module wwdm_monitor #(
    parameter int unsigned FAULT_CYC = 20,
    parameter int unsigned ACT_CYC   = 100
) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        heartbeat_input,
    input wire logic        window_check_enable_low,
    input wire logic        rail_primary_good,
    input wire logic        rail_secondary_good,
    input wire logic [31:0] max_interval_cycles,
    input wire logic        reset_out_low,
    input wire logic        fast_fault,
    input wire logic        slow_fault,
    input wire logic        fault_internal_flag,
    input wire logic        watchdog_active
);
    localparam int FL = FAULT_CYC - 1;
    logic [31:0] hb_cnt_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Cycles since the last rising edge at the heartbeat pin
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn)
            hb_cnt_r <= '0;
        else
            hb_cnt_r <= $rose(heartbeat_input) ? '0 : hb_cnt_r + 1;
    end
    fault_cause_a: assert property (
        $fell(reset_out_low) |-> fast_fault || slow_fault) else $error("no cause");
    pulse_len_a: assert property (
        $fell(reset_out_low) |-> ##FL !reset_out_low ##1 reset_out_low)
        else $error("reset pulse length wrong");
    flag_track_a: assert property (
        fault_internal_flag == !reset_out_low) else $error("flag mismatch");
    one_fault_a: assert property (
        !(fast_fault && slow_fault)) else $error("fast and slow together");
    off_quiet_a: assert property (
        !watchdog_active |-> reset_out_low && !fast_fault && !slow_fault)
        else $error("fault while idle");
    disarm_a: assert property (
        (window_check_enable_low || !rail_primary_good || !rail_secondary_good)
        |-> ##[1:4] !watchdog_active) else $error("still armed");
    arm_delay_a: assert property (
        $rose(watchdog_active) |-> $past(rail_primary_good, ACT_CYC)
        && $past(rail_secondary_good, ACT_CYC)) else $error("armed early");
    slow_gap_a: assert property (
        slow_fault |-> hb_cnt_r >= max_interval_cycles) else $error("early slow");
endmodule
bind wwdm_top wwdm_monitor #(.FAULT_CYC(FAULT_CYC), .ACT_CYC(ACT_CYC)) mon_u (
    .mclk, .rstn, .heartbeat_input, .window_check_enable_low,
    .rail_primary_good, .rail_secondary_good, .max_interval_cycles,
    .reset_out_low, .fast_fault, .slow_fault, .fault_internal_flag,
    .watchdog_active);

// ==== testbench/wwdm_host.sv ====
// Host model that drives the heartbeat clock
`timescale 1ns/1ps
module wwdm_host (
    input  wire logic        mclk,
    input  wire logic [31:0] period,
    output logic             heartbeat_input
);
    logic [31:0] cnt_r = '0;
    // One rising edge each period cycles; zero holds the line low
    always @(posedge mclk)
        cnt_r <= #1 (cnt_r + 1 >= period) ? '0 : cnt_r + 1;
    assign heartbeat_input = cnt_r < period / 2;
endmodule

// ==== testbench/wwdm_tb.sv ====
// Self-checking bench for the window watchdog monitor
`timescale 1ns/1ps
module wwdm_tb;
    logic        mclk, rstn, heartbeat_input, window_check_enable_low;
    logic        rail_primary_good, rail_secondary_good, reset_out_low;
    logic        fast_fault, slow_fault, fault_internal_flag, watchdog_active;
    logic [31:0] period, max_interval_cycles;
    int          fails, check_count, nf, ns, cyc;
    localparam int FAULT_N = 20;
    wwdm_top #(.FAULT_CYC(FAULT_N), .ACT_CYC(100)) dut_u (.mclk, .rstn,
        .heartbeat_input, .window_check_enable_low, .rail_primary_good,
        .rail_secondary_good, .max_interval_cycles, .reset_out_low,
        .fast_fault, .slow_fault, .fault_internal_flag, .watchdog_active);
    wwdm_host host_u (.mclk, .period, .heartbeat_input);
    task end_sim;
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %0d exp %0d", $time, got, exp);
        end
    endtask
    task run(input logic [31:0] p, input int n);
        period = p;
        nf = 0;
        ns = 0;
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task t_back;
        run(32'h28, 120);
        run(32'h28, 300);
        chk(nf + ns, 0);
    endtask
    task t_fast;
        run(32'h5, 100);
        chk(nf != 0 && ns == 0, 1);
        t_back;
    endtask
    task t_slow;
        run(32'h78, 400);
        chk(ns != 0 && nf == 0, 1);
        t_back;
    endtask
    task t_miss;
        run(32'h0, 200);
        chk(ns, 1);
        run(32'h0, 200);
        chk(ns, 1);
        t_pulse;
    endtask
    // Width of one reset pulse on the pin and on the internal flag
    task t_pulse;
        int wl, wf;
        wl = 0;
        wf = 0;
        while (reset_out_low !== 1'b0) begin
            @(posedge mclk);
            #1;
        end
        while (reset_out_low === 1'b0 || fault_internal_flag === 1'b1) begin
            wl += (reset_out_low === 1'b0);
            wf += (fault_internal_flag === 1'b1);
            @(posedge mclk);
            #1;
        end
        chk(wl, FAULT_N);
        chk(wf, FAULT_N);
    endtask
    // Spacing exactly at the minimum and at the maximum is accepted
    task t_limits;
        run(32'ha, 120);
        run(32'ha, 300);
        chk(nf + ns, 0);
        run(32'h50, 200);
        run(32'h50, 400);
        chk(nf + ns, 0);
    endtask
    task t_off;
        window_check_enable_low = 1'b1;
        run(32'h0, 400);
        chk(watchdog_active + ns, 0);
        window_check_enable_low = 1'b0;
        rail_primary_good = 1'b0;
        run(32'h0, 200);
        rail_primary_good = 1'b1;
        rail_secondary_good = 1'b0;
        run(32'h0, 200);
        chk(watchdog_active + ns, 0);
        rail_secondary_good = 1'b1;
        run(32'h28, 95);
        chk(watchdog_active, 0);
        run(32'h28, 30);
        chk(watchdog_active, 1);
    endtask
    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Count fault pulses mid-cycle, where outputs are settled
    always @(negedge mclk) begin
        cyc++;
        nf += (fast_fault !== 1'b0);
        ns += (slow_fault !== 1'b0);
        if (cyc == 9000) begin
            fails++;
            end_sim();
        end
    end
    // Reset, then the scenarios in turn
    initial begin
        {fails, check_count, nf, ns, cyc} = '0;
        rstn = 1'b0;
        window_check_enable_low = 1'b0;
        rail_primary_good = 1'b1;
        rail_secondary_good = 1'b1;
        max_interval_cycles = 32'h50;
        period = 32'h28;
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        run(32'h28, 600);
        chk(nf + ns + !watchdog_active, 0);
        t_limits;
        t_fast;
        t_slow;
        t_miss;
        t_off;
        end_sim();
    end
endmodule
